// ### hdl/gtc_core.sv
// 16-bit general timer counter core with clock select, prescaler and four modes
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - flags set only when counting steps into a value, never on software loads
// - 16-bit counter; mode field selects stop, up, continuous or up/down
// - each divided timer clock rising edge moves the running counter by one
// - software reads and writes the counter value at any time
// - source field picks auxiliary, main or external timer clock
// - divider field passes the clock or divides it by 2, 4 or 8
// - prescaler cleared only by reset or clear bit, never readable
// - period zero halts up and up/down; nonzero write restarts upward from zero
// - clear bit zeroes counter and prescaler; counting resumes upward unless stopped
// - writing zero to counter makes counting proceed upward from zero
// - entering or leaving stop mode leaves the counter value unchanged
// - direction bit survives stop, resumes in up/down, cleared by clear bit
// - up mode restarts from zero once counter equals or exceeds period
// - up mode sets match flag at period, overflow on period to zero
// - flags set regardless of enables; request needs own and global enable
// - smaller period in clock high acts next edge, in low one clock later
// - equal or larger period written while running just extends counting
// - continuous mode counts from present value to all ones, wraps to zero
// - continuous mode sets overflow when stepping from all ones to zero
// - continuous mode uses the period register as plain compare value
// - up/down counts up to period then down to zero and repeats
// - up/down sets match entering period, overflow stepping from one to zero
// - period rewritten while counting down applies only after reaching zero

module gtc_core (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_aux_clk,
  input  wire logic        i_main_clk,
  input  wire logic        i_ext_timer_clk,
  input  wire logic        i_global_irq_en,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  output logic             o_irq_req
);

  // ==========================================================================
  // state
  // ==========================================================================
  gtc_pkg::gtc_state_t state_reg;
  gtc_pkg::gtc_state_t state_next;

  // decoded strobes and timing events, shared with the checks below
  logic        wr_ctl;
  logic        wr_cnt;
  logic        wr_per;
  logic        wr_sts;
  logic        clr;
  logic        src_lvl;
  logic        src_rise;
  logic        tick;
  logic        phase_high;
  logic        halted;
  logic        set_ovf;
  logic        set_match;
  logic [15:0] cnt_inc;
  logic [15:0] cnt_dec;

  assign wr_ctl  = i_wr && (i_addr == gtc_pkg::ADDR_CONTROL);
  assign wr_cnt  = i_wr && (i_addr == gtc_pkg::ADDR_COUNTER);
  assign wr_per  = i_wr && (i_addr == gtc_pkg::ADDR_PERIOD);
  assign wr_sts  = i_wr && (i_addr == gtc_pkg::ADDR_STATUS);
  assign clr     = wr_ctl && i_wdata[gtc_pkg::CTL_CLEAR_BIT];
  assign cnt_inc = state_reg.cnt + gtc_pkg::CNT_ONE;
  assign cnt_dec = state_reg.cnt - gtc_pkg::CNT_ONE;

  // ==========================================================================
  // clock source, prescaler and timer clock phase
  // ==========================================================================
  // only the second synchroniser stage is looked at; switching source while
  // running can fake an edge, which is why software must halt first
  always_comb begin
    case (state_reg.src_sel)
      gtc_pkg::SRC_AUX:  src_lvl = state_reg.sync2[1];
      gtc_pkg::SRC_MAIN: src_lvl = state_reg.sync2[2];
      default:           src_lvl = state_reg.sync2[0];
    endcase
  end

  assign src_rise = src_lvl && !state_reg.src_prev;

  // divided clock rises when its top prescaler bit goes from 0 to 1,
  // so that bit being high marks the high phase of the timer clock
  always_comb begin
    case (state_reg.div_sel)
      gtc_pkg::DIV_2: begin
        tick       = src_rise && (state_reg.presc[0] == 1'b0);
        phase_high = state_reg.presc[0];
      end
      gtc_pkg::DIV_4: begin
        tick       = src_rise && (state_reg.presc[1:0] == 2'h1);
        phase_high = state_reg.presc[1];
      end
      gtc_pkg::DIV_8: begin
        tick       = src_rise && (state_reg.presc[2:0] == 3'h3);
        phase_high = state_reg.presc[2];
      end
      default: begin
        tick       = src_rise;
        phase_high = src_lvl;
      end
    endcase
  end

  // a zero period in up or up/down freezes the counter
  assign halted = (state_reg.mode == gtc_pkg::GTC_STOP) ||
                  (((state_reg.mode == gtc_pkg::GTC_UP) ||
                    (state_reg.mode == gtc_pkg::GTC_UPDN)) &&
                   (state_reg.eff == gtc_pkg::CNT_ZERO));

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    state_next          = state_reg;
    set_ovf             = 1'b0;
    set_match           = 1'b0;
    state_next.sync1    = {i_main_clk, i_aux_clk, i_ext_timer_clk};
    state_next.sync2    = state_reg.sync1;
    state_next.src_prev = src_lvl;

    // prescaler runs on every source edge, whatever the mode
    if (src_rise) begin
      state_next.presc = state_reg.presc + 3'h1;
    end

    // counting step; only this path raises flags, loads never do
    if (tick && !halted) begin
      case (state_reg.mode)
        gtc_pkg::GTC_UP: begin
          if (state_reg.cnt >= state_reg.eff) begin
            state_next.cnt = gtc_pkg::CNT_ZERO;
            set_ovf        = (state_reg.cnt == state_reg.eff);
          end else begin
            state_next.cnt = cnt_inc;
            set_match      = (cnt_inc == state_reg.eff);
          end
        end
        gtc_pkg::GTC_CONT: begin
          state_next.cnt = cnt_inc;
          set_ovf        = (state_reg.cnt == gtc_pkg::CNT_MAX);
          set_match      = (cnt_inc == state_reg.eff);
        end
        gtc_pkg::GTC_UPDN: begin
          if (!state_reg.dir_down) begin
            if (state_reg.cnt >= state_reg.eff) begin
              state_next.dir_down = 1'b1;
              state_next.cnt      = cnt_dec;
            end else begin
              state_next.cnt = cnt_inc;
              set_match      = (cnt_inc == state_reg.eff);
            end
          end else if (state_reg.cnt == gtc_pkg::CNT_ZERO) begin
            state_next.dir_down = 1'b0;
            state_next.cnt      = cnt_inc;
          end else begin
            state_next.cnt = cnt_dec;
            set_ovf        = (state_reg.cnt == gtc_pkg::CNT_ONE);
          end
        end
        default: begin
          state_next.cnt = state_reg.cnt;
        end
      endcase
      // a smaller period written in the low phase waited for this edge
      if (state_reg.defer_tick) begin
        state_next.eff        = state_reg.period;
        state_next.defer_tick = 1'b0;
      end
      // a period written on the way down waits until zero is reached
      if (state_reg.defer_zero && (state_next.cnt == gtc_pkg::CNT_ZERO)) begin
        state_next.eff        = state_reg.period;
        state_next.defer_zero = 1'b0;
      end
    end

    // period writes; comparison is made against the period in force now
    // in continuous the value is a plain compare, so it is never held back
    if (wr_per) begin
      state_next.period     = i_wdata;
      state_next.defer_tick = 1'b0;
      state_next.defer_zero = 1'b0;
      if (((state_reg.mode == gtc_pkg::GTC_UP) || (state_reg.mode == gtc_pkg::GTC_UPDN)) &&
          (state_reg.eff == gtc_pkg::CNT_ZERO) && (i_wdata != gtc_pkg::CNT_ZERO)) begin
        state_next.eff      = i_wdata;
        state_next.cnt      = gtc_pkg::CNT_ZERO;
        state_next.dir_down = 1'b0;
      end else if ((state_reg.mode == gtc_pkg::GTC_UPDN) && state_next.dir_down &&
                   (state_next.cnt != gtc_pkg::CNT_ZERO)) begin
        state_next.defer_zero = 1'b1;
      end else if (((state_reg.mode == gtc_pkg::GTC_UP) || (state_reg.mode == gtc_pkg::GTC_UPDN)) &&
                   (i_wdata < state_reg.eff) && !phase_high && !tick) begin
        state_next.defer_tick = 1'b1;
      end else begin
        state_next.eff = i_wdata;
      end
    end

    // counter load wins over a step in the same cycle
    if (wr_cnt) begin
      state_next.cnt = i_wdata;
      if (i_wdata == gtc_pkg::CNT_ZERO) begin
        state_next.dir_down = 1'b0;
      end
    end

    // control writes; the mode change alone never touches the count
    if (wr_ctl) begin
      state_next.mode    = gtc_pkg::gtc_mode_t'(i_wdata[gtc_pkg::CTL_MODE_LSB +: 2]);
      state_next.div_sel = i_wdata[gtc_pkg::CTL_DIV_LSB +: 2];
      state_next.src_sel = i_wdata[gtc_pkg::CTL_SRC_LSB +: 2];
    end
    if (clr) begin
      state_next.cnt      = gtc_pkg::CNT_ZERO;
      state_next.presc    = gtc_pkg::PRESC_RST;
      state_next.dir_down = 1'b0;
    end

    // flags: software writes the bit value, a hardware set in the same cycle wins
    if (wr_sts) begin
      state_next.ovf_flag   = i_wdata[gtc_pkg::STS_OVF_FLAG];
      state_next.match_flag = i_wdata[gtc_pkg::STS_MATCH_FLAG];
      state_next.ovf_en     = i_wdata[gtc_pkg::STS_OVF_EN];
      state_next.match_en   = i_wdata[gtc_pkg::STS_MATCH_EN];
    end
    if (set_ovf && !wr_cnt && !clr) begin
      state_next.ovf_flag = 1'b1;
    end
    if (set_match && !wr_cnt && !clr) begin
      state_next.match_flag = 1'b1;
    end

    // request needs the flag, its own enable and the global enable
    state_next.irq = i_global_irq_en &&
                     ((state_reg.ovf_flag && state_reg.ovf_en) ||
                      (state_reg.match_flag && state_reg.match_en));

    // read data stand only in the cycle after the strobe; prescaler has no address
    state_next.rdata = gtc_pkg::RST_WORD;
    if (i_rd) begin
      case (i_addr)
        gtc_pkg::ADDR_CONTROL: begin
          state_next.rdata[gtc_pkg::CTL_MODE_LSB +: 2] = state_reg.mode;
          state_next.rdata[gtc_pkg::CTL_DIV_LSB +: 2]  = state_reg.div_sel;
          state_next.rdata[gtc_pkg::CTL_SRC_LSB +: 2]  = state_reg.src_sel;
        end
        gtc_pkg::ADDR_COUNTER: state_next.rdata = state_reg.cnt;
        gtc_pkg::ADDR_PERIOD:  state_next.rdata = state_reg.period;
        gtc_pkg::ADDR_STATUS: begin
          state_next.rdata[gtc_pkg::STS_OVF_FLAG]   = state_reg.ovf_flag;
          state_next.rdata[gtc_pkg::STS_MATCH_FLAG] = state_reg.match_flag;
          state_next.rdata[gtc_pkg::STS_OVF_EN]     = state_reg.ovf_en;
          state_next.rdata[gtc_pkg::STS_MATCH_EN]   = state_reg.match_en;
        end
        default: state_next.rdata = gtc_pkg::RST_WORD;
      endcase
    end
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  // everything clears to a stopped timer with counting direction up
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata   = state_reg.rdata;
  assign o_irq_req = state_reg.irq;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // a quiet step: the counter moves on its own, with no counter load, clear or period write
  sequence s_quiet_tick;
    tick && !halted && !wr_cnt && !clr && !wr_per;
  endsequence

  sequence s_down_last;
    s_quiet_tick ##0 (state_reg.mode == gtc_pkg::GTC_UPDN) && state_reg.dir_down &&
      (state_reg.cnt == gtc_pkg::CNT_ONE);
  endsequence

  chk_stop_hold: assert property (
    (state_reg.mode == gtc_pkg::GTC_STOP) && !wr_cnt && !clr && !wr_per
      |=> $stable(state_reg.cnt))
    else $error("counter moved while stopped");

  chk_cont_step: assert property (
    s_quiet_tick ##0 (state_reg.mode == gtc_pkg::GTC_CONT) && !wr_ctl
      |=> state_reg.cnt == $past(state_reg.cnt) + gtc_pkg::CNT_ONE)
    else $error("continuous step is not plus one");

  chk_cont_wrap: assert property (
    s_quiet_tick ##0 (state_reg.mode == gtc_pkg::GTC_CONT) && !wr_ctl &&
      (state_reg.cnt == gtc_pkg::CNT_MAX) && !wr_sts
      |=> (state_reg.cnt == gtc_pkg::CNT_ZERO) && state_reg.ovf_flag)
    else $error("continuous wrap without overflow flag");

  chk_up_restart: assert property (
    s_quiet_tick ##0 (state_reg.mode == gtc_pkg::GTC_UP) && !wr_ctl &&
      (state_reg.cnt >= state_reg.eff)
      |=> state_reg.cnt == gtc_pkg::CNT_ZERO)
    else $error("up mode did not restart from zero");

  chk_updn_ovf: assert property (
    s_down_last ##0 !wr_ctl && !wr_sts
      |=> state_reg.ovf_flag && (state_reg.cnt == gtc_pkg::CNT_ZERO) ##1 (state_reg.ovf_flag || $past(wr_sts)))
    else $error("down count to zero lost overflow flag");

  chk_updn_turn: assert property (
    s_quiet_tick ##0 (state_reg.mode == gtc_pkg::GTC_UPDN) && !wr_ctl &&
      !state_reg.dir_down && (state_reg.cnt == state_reg.eff)
      |=> state_reg.dir_down && (state_reg.cnt == $past(state_reg.cnt) - gtc_pkg::CNT_ONE))
    else $error("up/down did not turn at period");

  chk_load_no_flag: assert property (
    wr_cnt |=> (state_reg.ovf_flag == $past(state_reg.ovf_flag)) &&
               (state_reg.match_flag == $past(state_reg.match_flag)))
    else $error("software load raised a flag");

  chk_clear_zero: assert property (
    clr |=> (state_reg.cnt == gtc_pkg::CNT_ZERO) && (state_reg.presc == gtc_pkg::PRESC_RST) &&
            !state_reg.dir_down)
    else $error("clear bit left counter, prescaler or direction");

  chk_zero_period: assert property (
    halted && (state_reg.mode != gtc_pkg::GTC_STOP) && !wr_cnt && !clr && !wr_per && !wr_ctl
      |=> $stable(state_reg.cnt))
    else $error("zero period did not halt the counter");

  chk_irq_gate: assert property (
    o_irq_req |-> $past(i_global_irq_en) &&
                  (($past(state_reg.ovf_flag) && $past(state_reg.ovf_en)) ||
                   ($past(state_reg.match_flag) && $past(state_reg.match_en))))
    else $error("request without flag and both enables");

  chk_read_count: assert property (
    i_rd && (i_addr == gtc_pkg::ADDR_COUNTER) |=> o_rdata == $past(state_reg.cnt) ##1
      o_rdata == gtc_pkg::RST_WORD || $past(i_rd))
    else $error("counter read returned wrong value");

  chk_up_match: assert property (
    s_quiet_tick ##0 (state_reg.mode == gtc_pkg::GTC_UP) && !wr_ctl && !wr_sts &&
      (state_reg.cnt < state_reg.eff) && (cnt_inc == state_reg.eff)
      |=> state_reg.match_flag && (state_reg.cnt == $past(state_reg.eff)))
    else $error("up mode reached period without match flag");

  chk_cont_match: assert property (
    s_quiet_tick ##0 (state_reg.mode == gtc_pkg::GTC_CONT) && !wr_ctl && !wr_sts &&
      (cnt_inc == state_reg.eff)
      |=> state_reg.match_flag)
    else $error("continuous step into compare value without match flag");

  chk_down_defer: assert property (
    wr_per && !tick && (state_reg.mode == gtc_pkg::GTC_UPDN) && state_reg.dir_down &&
      (state_reg.cnt != gtc_pkg::CNT_ZERO) && (state_reg.eff != gtc_pkg::CNT_ZERO)
      |=> (state_reg.eff == $past(state_reg.eff)) && state_reg.defer_zero)
    else $error("period took effect while counting down");

endmodule
`default_nettype wire

// ### common/gtc_pkg.sv
// constants, types and register map of the general timer counter core
package gtc_pkg;

  // ==========================================================================
  // register map (byte addresses on the register port)
  // ==========================================================================
  localparam logic [3:0] ADDR_CONTROL = 4'h0;  // timer_control_reg
  localparam logic [3:0] ADDR_COUNTER = 4'h4;  // counter_value_reg
  localparam logic [3:0] ADDR_PERIOD  = 4'h8;  // period_register
  localparam logic [3:0] ADDR_STATUS  = 4'hC;  // flags and their enables

  // ==========================================================================
  // control register fields
  // ==========================================================================
  localparam int CTL_CLEAR_BIT  = 2;  // counter_clear_bit, reads back as zero
  localparam int CTL_MODE_LSB   = 4;  // mode_select_low, mode_select_high above it
  localparam int CTL_DIV_LSB    = 6;  // prescale_low, prescale_high above it
  localparam int CTL_SRC_LSB    = 8;  // clock_source_low, clock_source_high above it

  // ==========================================================================
  // status register fields
  // ==========================================================================
  localparam int STS_OVF_FLAG   = 0;  // counter_overflow_flag
  localparam int STS_MATCH_FLAG = 1;  // period_match_flag
  localparam int STS_OVF_EN     = 4;
  localparam int STS_MATCH_EN   = 5;

  // ==========================================================================
  // values
  // ==========================================================================
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [2:0]  PRESC_RST = 3'h0;

  // source selection codes
  localparam logic [1:0] SRC_EXT  = 2'h0;
  localparam logic [1:0] SRC_AUX  = 2'h1;
  localparam logic [1:0] SRC_MAIN = 2'h2;

  // divider selection codes
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_2 = 2'h1;
  localparam logic [1:0] DIV_4 = 2'h2;
  localparam logic [1:0] DIV_8 = 2'h3;

  // counting modes, encoding fixed by the mode_select_field
  typedef enum logic [1:0] {
    GTC_STOP = 2'h0,
    GTC_UP   = 2'h1,
    GTC_CONT = 2'h2,
    GTC_UPDN = 2'h3
  } gtc_mode_t;

  // whole state of the core
  typedef struct packed {
    logic [2:0]  sync1;       // first synchroniser stage of the three clock pins
    logic [2:0]  sync2;       // second stage
    logic        src_prev;    // selected source level one cycle ago
    logic [2:0]  presc;       // prescaler, invisible to software
    gtc_mode_t   mode;
    logic [1:0]  src_sel;
    logic [1:0]  div_sel;
    logic [15:0] cnt;
    logic [15:0] period;      // value software wrote
    logic [15:0] eff;         // period the counter currently obeys
    logic        dir_down;
    logic        defer_tick;  // adopt period after one more timer clock
    logic        defer_zero;  // adopt period once counting down reaches zero
    logic        ovf_flag;
    logic        match_flag;
    logic        ovf_en;
    logic        match_en;
    logic [15:0] rdata;
    logic        irq;
  } gtc_state_t;

endpackage

// ### tb/tb_gtc_core.sv
// self-checking bench for the general timer counter core
`timescale 1ns/100ps
`default_nettype none
module tb_gtc_core;
  // ==========================================================================
  // stimulus, observation and counters
  // ==========================================================================
  logic        i_clk           = 1'b0;
  logic        i_rst_n         = 1'b0;
  logic [2:0]  pin             = 3'h0;  // ext, aux, main pins in source code order
  logic        i_global_irq_en = 1'b0;
  logic [3:0]  i_addr          = 4'h0;
  logic [15:0] i_wdata         = 16'h0000;
  logic        i_wr            = 1'b0;
  logic        i_rd            = 1'b0;
  logic [15:0] o_rdata;
  logic        o_irq_req;
  int          n_errors        = 0;
  int          n_checks        = 0;

  gtc_core gtc_core_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_aux_clk(pin[1]), .i_main_clk(pin[2]),
    .i_ext_timer_clk(pin[0]), .i_global_irq_en(i_global_irq_en), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq_req(o_irq_req));

  // 250 MHz system clock
  always #2 i_clk = ~i_clk;

  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 check(o_rdata, exp);
  endtask

  // pins stay 5 cycles high and low so the two-flop synchroniser never misses an edge
  task automatic pulse(input logic [2:0] mask, input int n);
    repeat (n) begin
      repeat (5) @(posedge i_clk);
      pin <= mask;
      repeat (5) @(posedge i_clk);
      pin <= 3'h0;
    end
    repeat (6) @(posedge i_clk);
  endtask

  function automatic logic [15:0] ctl(input logic [1:0] m, input logic [1:0] d, input logic [1:0] s,
                                      input logic c);
    return {6'h00, s, d, m, 1'b0, c, 2'h0};
  endfunction

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_reset;
    rc(gtc_pkg::ADDR_CONTROL, 16'h0000);
    rc(gtc_pkg::ADDR_COUNTER, 16'h0000);
    rc(gtc_pkg::ADDR_STATUS, 16'h0000);
    rc(4'h2, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_up;
    wr(gtc_pkg::ADDR_PERIOD, 16'h0003);
    wr(gtc_pkg::ADDR_CONTROL, ctl(gtc_pkg::GTC_UP, gtc_pkg::DIV_1, gtc_pkg::SRC_MAIN, 1'b1));
    pulse(3'h4, 3);
    rc(gtc_pkg::ADDR_COUNTER, 16'h0003);
    rc(gtc_pkg::ADDR_STATUS, 16'h0002);
    pulse(3'h4, 1);
    rc(gtc_pkg::ADDR_COUNTER, 16'h0000);
    rc(gtc_pkg::ADDR_STATUS, 16'h0003);
    wr(gtc_pkg::ADDR_STATUS, 16'h0033);
    i_global_irq_en <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1 check({15'h0000, o_irq_req}, 16'h0001);
    @(posedge i_clk);
    i_global_irq_en <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1 check({15'h0000, o_irq_req}, 16'h0000);
    wr(gtc_pkg::ADDR_STATUS, 16'h0000);
    pulse(3'h4, 2);
    wr(gtc_pkg::ADDR_PERIOD, 16'h0006);
    pulse(3'h4, 2);
    rc(gtc_pkg::ADDR_COUNTER, 16'h0004);
    // a load of the period value while halted must not count as stepping into it
    wr(gtc_pkg::ADDR_CONTROL, ctl(gtc_pkg::GTC_STOP, gtc_pkg::DIV_1, gtc_pkg::SRC_MAIN, 1'b0));
    pulse(3'h4, 3);
    rc(gtc_pkg::ADDR_COUNTER, 16'h0004);
    wr(gtc_pkg::ADDR_COUNTER, 16'h0006);
    rc(gtc_pkg::ADDR_STATUS, 16'h0000);
    $display("test up done");
  endtask

  task automatic t_cont;
    wr(gtc_pkg::ADDR_CONTROL, ctl(gtc_pkg::GTC_CONT, gtc_pkg::DIV_1, gtc_pkg::SRC_MAIN, 1'b0));
    wr(gtc_pkg::ADDR_COUNTER, 16'hFFFE);
    pulse(3'h4, 2);
    rc(gtc_pkg::ADDR_COUNTER, 16'h0000);
    rc(gtc_pkg::ADDR_STATUS, 16'h0001);
    wr(gtc_pkg::ADDR_PERIOD, 16'h0001);
    pulse(3'h4, 3);
    rc(gtc_pkg::ADDR_COUNTER, 16'h0003);
    rc(gtc_pkg::ADDR_STATUS, 16'h0003);
    $display("test continuous done");
  endtask

  task automatic t_updn;
    wr(gtc_pkg::ADDR_STATUS, 16'h0000);
    wr(gtc_pkg::ADDR_PERIOD, 16'h0002);
    wr(gtc_pkg::ADDR_CONTROL, ctl(gtc_pkg::GTC_UPDN, gtc_pkg::DIV_1, gtc_pkg::SRC_MAIN, 1'b1));
    pulse(3'h4, 3);
    rc(gtc_pkg::ADDR_COUNTER, 16'h0001);
    rc(gtc_pkg::ADDR_STATUS, 16'h0002);
    pulse(3'h4, 1);
    rc(gtc_pkg::ADDR_STATUS, 16'h0003);
    pulse(3'h4, 3);
    wr(gtc_pkg::ADDR_CONTROL, ctl(gtc_pkg::GTC_STOP, gtc_pkg::DIV_1, gtc_pkg::SRC_MAIN, 1'b0));
    pulse(3'h4, 2);
    rc(gtc_pkg::ADDR_COUNTER, 16'h0001);
    wr(gtc_pkg::ADDR_CONTROL, ctl(gtc_pkg::GTC_UPDN, gtc_pkg::DIV_1, gtc_pkg::SRC_MAIN, 1'b0));
    pulse(3'h4, 1);
    rc(gtc_pkg::ADDR_COUNTER, 16'h0000);
    pulse(3'h4, 3);
    // clear while descending: a nonzero load afterwards must still climb
    wr(gtc_pkg::ADDR_CONTROL, ctl(gtc_pkg::GTC_UPDN, gtc_pkg::DIV_1, gtc_pkg::SRC_MAIN, 1'b1));
    rc(gtc_pkg::ADDR_COUNTER, 16'h0000);
    wr(gtc_pkg::ADDR_COUNTER, 16'h0001);
    pulse(3'h4, 1);
    rc(gtc_pkg::ADDR_COUNTER, 16'h0002);
    // a smaller period written on the way down waits until zero is reached
    wr(gtc_pkg::ADDR_PERIOD, 16'h0004);
    pulse(3'h4, 3);
    wr(gtc_pkg::ADDR_PERIOD, 16'h0002);
    pulse(3'h4, 3);
    rc(gtc_pkg::ADDR_COUNTER, 16'h0000);
    pulse(3'h4, 3);
    rc(gtc_pkg::ADDR_COUNTER, 16'h0001);
    $display("test up/down done");
  endtask

  task automatic t_div_src;
    for (int d = 1; d < 4; d++) begin
      wr(gtc_pkg::ADDR_CONTROL, ctl(gtc_pkg::GTC_CONT, 2'(d), gtc_pkg::SRC_MAIN, 1'b1));
      // after a clear the divided clock first rises half a period in, then every period
      pulse(3'h4, 1 << (d - 1));
      rc(gtc_pkg::ADDR_COUNTER, 16'h0001);
      pulse(3'h4, (1 << d) - 1);
      rc(gtc_pkg::ADDR_COUNTER, 16'h0001);
      pulse(3'h4, 1);
      rc(gtc_pkg::ADDR_COUNTER, 16'h0002);
    end
    // halt before each source switch, then only the chosen pin may move the counter
    for (int s = 0; s < 3; s++) begin
      wr(gtc_pkg::ADDR_CONTROL, ctl(gtc_pkg::GTC_STOP, gtc_pkg::DIV_1, 2'(s), 1'b0));
      wr(gtc_pkg::ADDR_CONTROL, ctl(gtc_pkg::GTC_CONT, gtc_pkg::DIV_1, 2'(s), 1'b1));
      pulse(~(3'h1 << s), 2);
      rc(gtc_pkg::ADDR_COUNTER, 16'h0000);
      pulse(3'h1 << s, 2);
      rc(gtc_pkg::ADDR_COUNTER, 16'h0002);
    end
    $display("test divider and source done");
  endtask

  task automatic t_zero;
    wr(gtc_pkg::ADDR_PERIOD, 16'h0004);
    wr(gtc_pkg::ADDR_CONTROL, ctl(gtc_pkg::GTC_UP, gtc_pkg::DIV_1, gtc_pkg::SRC_MAIN, 1'b1));
    pulse(3'h4, 2);
    wr(gtc_pkg::ADDR_PERIOD, 16'h0000);
    pulse(3'h4, 2);
    // zero is a smaller period written in the low phase, so one more step passes first
    rc(gtc_pkg::ADDR_COUNTER, 16'h0003);
    wr(gtc_pkg::ADDR_PERIOD, 16'h0004);
    pulse(3'h4, 1);
    rc(gtc_pkg::ADDR_COUNTER, 16'h0001);
    pulse(3'h4, 1);
    wr(gtc_pkg::ADDR_COUNTER, 16'h0000);
    pulse(3'h4, 1);
    rc(gtc_pkg::ADDR_COUNTER, 16'h0001);
    $display("test period zero done");
  endtask

  // ==========================================================================
  // verdict, watchdog and main sequence
  // ==========================================================================
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // the tests need about 1200 cycles; a hang ends the run after 10000
  initial begin
    #40000;
    n_errors++;
    end_sim();
  end

  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    t_reset();
    t_up();
    t_cont();
    t_updn();
    t_div_src();
    t_zero();
    end_sim();
  end
endmodule
`default_nettype wire
